// File: rtl/rtc_pkg.sv
// Package for the control, timestamp, trim and RAM pointer register bank.
// Assumes a byte-wide register port decoded from the serial interface.
package rtc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CONTROL_STATUS_1 = 8'h00;
  localparam logic [7:0] ADDR_CONTROL_STATUS_2 = 8'h01;
  localparam logic [7:0] ADDR_CONTROL_STATUS_3 = 8'h02;
  localparam logic [7:0] ADDR_TIMESTAMP_SECONDS = 8'h13;
  localparam logic [7:0] ADDR_TIMESTAMP_MINUTES = 8'h14;
  localparam logic [7:0] ADDR_TIMESTAMP_HOURS = 8'h15;
  localparam logic [7:0] ADDR_TIMESTAMP_DAY = 8'h16;
  localparam logic [7:0] ADDR_TIMESTAMP_MONTH = 8'h17;
  localparam logic [7:0] ADDR_TIMESTAMP_YEAR = 8'h18;
  localparam logic [7:0] ADDR_AGING_TRIM = 8'h19;
  localparam logic [7:0] ADDR_RAM_POINTER_HIGH = 8'h1a;
  localparam logic [7:0] ADDR_RAM_POINTER_LOW = 8'h1b;
  localparam logic [7:0] ADDR_RAM_WRITE_PORT = 8'h1c;
  localparam logic [7:0] ADDR_RAM_READ_PORT = 8'h1d;

  // ----------------------------------------------------------------
  // Control register 1 fields
  // ----------------------------------------------------------------
  localparam int BIT_EXTERNAL_CLOCK_TEST_SELECT = 7;
  localparam int BIT_TEST_RESERVED = 6;
  localparam int BIT_CLOCK_HALT = 5;
  localparam int BIT_MIDLEVEL_CAPTURE_FLAG = 4;
  localparam int BIT_POWERON_OVERRIDE_ENABLE = 3;
  localparam int BIT_HOUR_MODE_12 = 2;
  localparam int BIT_MINUTE_IRQ_ENABLE = 1;
  localparam int BIT_SECOND_IRQ_ENABLE = 0;

  // ----------------------------------------------------------------
  // Implemented bits of each register
  // ----------------------------------------------------------------
  localparam logic [7:0] MASK_CONTROL_STATUS_1 = 8'hbf;
  localparam logic [7:0] MASK_TIMESTAMP_SECONDS = 8'h7f;
  localparam logic [7:0] MASK_TIMESTAMP_MINUTES = 8'h7f;
  localparam logic [7:0] MASK_TIMESTAMP_HOURS = 8'h3f;
  localparam logic [7:0] MASK_TIMESTAMP_DAY = 8'h3f;
  localparam logic [7:0] MASK_TIMESTAMP_MONTH = 8'h1f;
  localparam logic [7:0] MASK_TIMESTAMP_YEAR = 8'hff;
  localparam logic [7:0] MASK_AGING_TRIM = 8'h0f;
  localparam logic [7:0] MASK_RAM_POINTER_HIGH = 8'h01;
  localparam logic [7:0] MASK_RAM_POINTER_LOW = 8'hff;
  localparam logic [7:0] MASK_RAM_READ_PORT = 8'hff;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RESET_CONTROL_STATUS_1 = 8'h08;
  localparam logic [3:0] RESET_AGING_TRIM = 4'h8;
  localparam logic [8:0] RESET_RAM_POINTER = 9'h000;

  // Clock output selections that survive a halt: 32.768, 16.384, 8.192 kHz
  localparam logic [2:0] CLOCK_OUTPUT_SEL_LAST_KEPT = 3'h2;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rtc_req_s;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } rtc_rsp_s;

  // Live calendar in BCD, highest field first
  typedef struct packed {
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] day;
    logic [7:0] hours;
    logic [7:0] minutes;
    logic [7:0] seconds;
  } rtc_time_s;

  typedef struct packed {
    logic [7:0] ctrl1;
    rtc_time_s stamp;
    logic [3:0] aging;
    logic [8:0] ram_ptr;
    rtc_rsp_s rsp;
    logic ram_wr_stb;
    logic ram_rd_stb;
    logic [7:0] ram_wdata;
    logic clock_output_enable;
    logic divider_clear;
  } rtc_state_s;

endpackage

// File: rtl/rtc_ctrl_ts_regs.sv
// Control register 1, captured timestamp, aging trim and RAM pointer/port bank.
// Assumes the serial front end presents one-cycle byte requests on clk,
// and that the RAM array itself sits outside and answers combinationally.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Every unimplemented register bit reads back as zero.
// - Undefined bits power up arbitrary and are left untouched by reset.
// - The three control registers sit at offsets 0, 1 and 2.
// - Bit 7 of control register 1 selects external clock test mode when set.
// - Bit 5 of control register 1 halts the timekeeping clock when set.
// - While halted, the divider chain is held cleared.
// - While halted, the clock output stays alive for its three fastest settings.
// - A mid-level capture input sets bit 4 of control register 1.
// - The mid-level interrupt holds until the host clears the flag.
// - Bit 3 of control register 1 resets to one and enables power-on override reception.
// - Captured seconds at offset 13h hold BCD 0 to 59 with bit 7 unimplemented.
module rtc_control_timestamp_regs
  import rtc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port from the serial interface
  input var rtc_req_s req,
  output var rtc_rsp_s rsp,
  // Timestamp capture
  input wire logic capture_stb,
  input wire logic midlevel_detect,
  input var rtc_time_s live_time,
  // Clock output
  input wire logic [2:0] clock_output_freq_sel,
  output logic clock_output_pin_enable,
  // Control outputs
  output logic external_clock_test_select,
  output logic clock_halt,
  output logic divider_clear,
  output logic midlevel_irq,
  output logic poweron_override_enable,
  output logic hour_mode_12,
  output logic minute_irq_enable,
  output logic second_irq_enable,
  output logic [3:0] aging_trim,
  // External RAM array
  output logic [8:0] ram_pointer,
  output logic ram_write_stb,
  output logic [7:0] ram_write_data,
  output logic ram_read_stb,
  input wire logic [7:0] ram_read_data
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // Implemented bits per offset; everything else is reserved or unmapped
  // only control offset 0 decoded; offsets 1 and 2 fall to the default of zero
  function automatic logic [7:0] impl_mask(input logic [7:0] a);
    unique case (a)
      ADDR_CONTROL_STATUS_1: impl_mask = MASK_CONTROL_STATUS_1;
      ADDR_TIMESTAMP_SECONDS: impl_mask = MASK_TIMESTAMP_SECONDS;
      ADDR_TIMESTAMP_MINUTES: impl_mask = MASK_TIMESTAMP_MINUTES;
      ADDR_TIMESTAMP_HOURS: impl_mask = MASK_TIMESTAMP_HOURS;
      ADDR_TIMESTAMP_DAY: impl_mask = MASK_TIMESTAMP_DAY;
      ADDR_TIMESTAMP_MONTH: impl_mask = MASK_TIMESTAMP_MONTH;
      ADDR_TIMESTAMP_YEAR: impl_mask = MASK_TIMESTAMP_YEAR;
      ADDR_AGING_TRIM: impl_mask = MASK_AGING_TRIM;
      ADDR_RAM_POINTER_HIGH: impl_mask = MASK_RAM_POINTER_HIGH;
      ADDR_RAM_POINTER_LOW: impl_mask = MASK_RAM_POINTER_LOW;
      ADDR_RAM_READ_PORT: impl_mask = MASK_RAM_READ_PORT;
      default: impl_mask = 8'h00;
    endcase
  endfunction

  rtc_state_s state;
  rtc_state_s next_state;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] wd;
    logic [7:0] rd_raw;
    logic ram_access;
    wd = req.wdata & impl_mask(req.addr);
    rd_raw = 8'h00;
    ram_access = 1'b0;
    next_state = state;
    next_state.ram_wr_stb = 1'b0;
    next_state.ram_rd_stb = 1'b0;
    next_state.rsp.valid = 1'b0;

    // Host writes
    if (req.wr) begin
      unique case (req.addr)
        ADDR_CONTROL_STATUS_1: begin
          next_state.ctrl1[BIT_EXTERNAL_CLOCK_TEST_SELECT] = wd[BIT_EXTERNAL_CLOCK_TEST_SELECT];
          next_state.ctrl1[BIT_CLOCK_HALT] = wd[BIT_CLOCK_HALT];
          next_state.ctrl1[BIT_POWERON_OVERRIDE_ENABLE] = wd[BIT_POWERON_OVERRIDE_ENABLE];
          next_state.ctrl1[BIT_HOUR_MODE_12] = wd[BIT_HOUR_MODE_12];
          next_state.ctrl1[BIT_MINUTE_IRQ_ENABLE] = wd[BIT_MINUTE_IRQ_ENABLE];
          next_state.ctrl1[BIT_SECOND_IRQ_ENABLE] = wd[BIT_SECOND_IRQ_ENABLE];
          // host can only clear the flag
          if (!wd[BIT_MIDLEVEL_CAPTURE_FLAG]) begin
            next_state.ctrl1[BIT_MIDLEVEL_CAPTURE_FLAG] = 1'b0;
          end
        end
        // seconds keep bit 7 at zero
        ADDR_TIMESTAMP_SECONDS: next_state.stamp.seconds = wd;
        ADDR_TIMESTAMP_MINUTES: next_state.stamp.minutes = wd;
        ADDR_TIMESTAMP_HOURS: next_state.stamp.hours = wd;
        ADDR_TIMESTAMP_DAY: next_state.stamp.day = wd;
        ADDR_TIMESTAMP_MONTH: next_state.stamp.month = wd;
        ADDR_TIMESTAMP_YEAR: next_state.stamp.year = wd;
        ADDR_AGING_TRIM: next_state.aging = wd[3:0];
        ADDR_RAM_POINTER_HIGH: next_state.ram_ptr[8] = wd[0];
        ADDR_RAM_POINTER_LOW: next_state.ram_ptr[7:0] = wd;
        ADDR_RAM_WRITE_PORT: begin
          next_state.ram_wr_stb = 1'b1;
          next_state.ram_wdata = req.wdata;
          ram_access = 1'b1;
        end
        default: begin
        end
      endcase
    end

    // Host reads, answered one cycle later
    if (req.rd) begin
      unique case (req.addr)
        ADDR_CONTROL_STATUS_1: rd_raw = state.ctrl1;
        ADDR_TIMESTAMP_SECONDS: rd_raw = state.stamp.seconds;
        ADDR_TIMESTAMP_MINUTES: rd_raw = state.stamp.minutes;
        ADDR_TIMESTAMP_HOURS: rd_raw = state.stamp.hours;
        ADDR_TIMESTAMP_DAY: rd_raw = state.stamp.day;
        ADDR_TIMESTAMP_MONTH: rd_raw = state.stamp.month;
        ADDR_TIMESTAMP_YEAR: rd_raw = state.stamp.year;
        ADDR_AGING_TRIM: rd_raw = {4'h0, state.aging};
        ADDR_RAM_POINTER_HIGH: rd_raw = {7'h00, state.ram_ptr[8]};
        ADDR_RAM_POINTER_LOW: rd_raw = state.ram_ptr[7:0];
        ADDR_RAM_READ_PORT: begin
          rd_raw = ram_read_data;
          next_state.ram_rd_stb = 1'b1;
          ram_access = 1'b1;
        end
        default: rd_raw = 8'h00;
      endcase
      // unimplemented and reserved bits read zero
      next_state.rsp.data = rd_raw & impl_mask(req.addr);
      next_state.rsp.valid = 1'b1;
    end

    // Streaming through the RAM ports walks the 512-byte space
    if (ram_access) begin
      next_state.ram_ptr = state.ram_ptr + 9'h001;
    end

    // Capture overrides a host write to the same register in that cycle
    if (capture_stb) begin
      next_state.stamp = live_time;
      next_state.stamp.seconds = live_time.seconds & MASK_TIMESTAMP_SECONDS;
      next_state.stamp.minutes = live_time.minutes & MASK_TIMESTAMP_MINUTES;
      next_state.stamp.hours = live_time.hours & MASK_TIMESTAMP_HOURS;
      next_state.stamp.day = live_time.day & MASK_TIMESTAMP_DAY;
      next_state.stamp.month = live_time.month & MASK_TIMESTAMP_MONTH;
    end

    // mid-level event sets the flag, winning over a clear
    if (midlevel_detect) begin
      next_state.ctrl1[BIT_MIDLEVEL_CAPTURE_FLAG] = 1'b1;
    end

    // the test bit is never stored, whatever the host wrote
    next_state.ctrl1[BIT_TEST_RESERVED] = 1'b0;

    // divider held cleared for as long as the halt bit stands
    next_state.divider_clear = next_state.ctrl1[BIT_CLOCK_HALT];
    // fast clock output settings run from the oscillator, ahead of the divider
    next_state.clock_output_enable = !next_state.ctrl1[BIT_CLOCK_HALT] ||
      (clock_output_freq_sel <= CLOCK_OUTPUT_SEL_LAST_KEPT);

    // reset touches only defined fields; timestamp keeps its contents
    if (rst) begin
      // override reception enabled out of reset
      next_state.ctrl1 = RESET_CONTROL_STATUS_1;
      next_state.aging = RESET_AGING_TRIM;
      next_state.ram_ptr = RESET_RAM_POINTER;
      next_state.rsp = '0;
      next_state.ram_wr_stb = 1'b0;
      next_state.ram_rd_stb = 1'b0;
      next_state.ram_wdata = 8'h00;
      next_state.clock_output_enable = 1'b1;
      next_state.divider_clear = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // No reset here: reset is folded into next_state so undefined fields survive it
  always_ff @(posedge clk) begin
    state <= next_state;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rsp = state.rsp;
  assign external_clock_test_select = state.ctrl1[BIT_EXTERNAL_CLOCK_TEST_SELECT];
  assign clock_halt = state.ctrl1[BIT_CLOCK_HALT];
  assign divider_clear = state.divider_clear;
  assign clock_output_pin_enable = state.clock_output_enable;
  assign midlevel_irq = state.ctrl1[BIT_MIDLEVEL_CAPTURE_FLAG];
  assign poweron_override_enable = state.ctrl1[BIT_POWERON_OVERRIDE_ENABLE];
  assign hour_mode_12 = state.ctrl1[BIT_HOUR_MODE_12];
  assign minute_irq_enable = state.ctrl1[BIT_MINUTE_IRQ_ENABLE];
  assign second_irq_enable = state.ctrl1[BIT_SECOND_IRQ_ENABLE];
  assign aging_trim = state.aging;
  assign ram_pointer = state.ram_ptr;
  assign ram_write_stb = state.ram_wr_stb;
  assign ram_write_data = state.ram_wdata;
  assign ram_read_stb = state.ram_rd_stb;

endmodule

`default_nettype wire

// File: tb/rtc_regs_asserts.sv
// Concurrent checks on the control and timestamp register bank.
// Sees only the bank's top-level ports; attached by the bind below.
`timescale 1ns/1ps
`default_nettype none
module rtc_regs_asserts
  import rtc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Observed ports
  input var rtc_req_s req,
  input var rtc_rsp_s rsp,
  input wire logic midlevel_detect,
  input wire logic [2:0] clock_output_freq_sel,
  input wire logic clock_output_pin_enable,
  input wire logic external_clock_test_select,
  input wire logic clock_halt,
  input wire logic divider_clear,
  input wire logic midlevel_irq,
  input wire logic poweron_override_enable,
  input wire logic [3:0] aging_trim
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // Request steps
  // ----------------------------------------------------------------
  sequence rd_of(logic [7:0] a);
    req.rd && req.addr == a;
  endsequence
  sequence wr_ctrl;
    req.wr && req.addr == ADDR_CONTROL_STATUS_1;
  endsequence
  ctrl_reserved_a: assert property (rd_of(ADDR_CONTROL_STATUS_1) |=> rsp.valid && !rsp.data[6])
    else $error("reserved control bit read back set");
  ctrl_offsets_a: assert property ((rd_of(ADDR_CONTROL_STATUS_2) or rd_of(ADDR_CONTROL_STATUS_3))
    |=> rsp.valid && rsp.data == 8'h00) else $error("outside control offset read nonzero");
  ctrl_write_a: assert property (wr_ctrl |=> external_clock_test_select == $past(req.wdata[7])
    && clock_halt == $past(req.wdata[5])) else $error("control write not applied");
  divider_hold_a: assert property (divider_clear == clock_halt)
    else $error("divider clear differs from halt");
  clock_output_kept_a: assert property (clock_output_pin_enable ==
    !(clock_halt && $past(clock_output_freq_sel) > CLOCK_OUTPUT_SEL_LAST_KEPT))
    else $error("clock output enable wrong");
  flag_set_a: assert property (midlevel_detect |=> midlevel_irq)
    else $error("midlevel flag not set");
  flag_hold_a: assert property (midlevel_irq && !(req.wr && req.addr == ADDR_CONTROL_STATUS_1
    && !req.wdata[4]) |=> midlevel_irq) else $error("midlevel flag dropped");
  flag_clear_a: assert property (wr_ctrl ##0 (!req.wdata[4] && !midlevel_detect) |=> !midlevel_irq)
    else $error("midlevel flag not cleared");
  override_reset_a: assert property ($fell(rst) |-> poweron_override_enable
    && aging_trim == RESET_AGING_TRIM) else $error("reset values wrong");
  sec_top_a: assert property (rd_of(ADDR_TIMESTAMP_SECONDS) |=> !rsp.data[7])
    else $error("captured seconds top bit set");
endmodule
bind rtc_control_timestamp_regs rtc_regs_asserts i_rtc_regs_asserts (.clk(clk), .rst(rst), .req(req), .rsp(rsp),
  .midlevel_detect(midlevel_detect), .clock_output_freq_sel(clock_output_freq_sel),
  .clock_output_pin_enable(clock_output_pin_enable), .external_clock_test_select(external_clock_test_select),
  .clock_halt(clock_halt), .divider_clear(divider_clear), .midlevel_irq(midlevel_irq),
  .poweron_override_enable(poweron_override_enable), .aging_trim(aging_trim));
`default_nettype wire

// File: tb/rtc_ram_model.sv
// Behavioural model of the 512-byte RAM array beside the register bank.
// Assumes the bank strobes a write in the same cycle as it advances the pointer.
`timescale 1ns/1ps
`default_nettype none
module rtc_ram_model
  import rtc_pkg::*;
(
  input wire logic clk,
  input wire logic [8:0] ram_pointer,
  input wire logic ram_write_stb,
  input wire logic [7:0] ram_write_data,
  output logic [7:0] ram_read_data
);
  logic [7:0] mem [512];
  // Seeded with a pattern so that only entries 03ch and 13ch start at zero
  initial for (int i = 0; i < 512; i++) mem[i] = i[7:0] ^ 8'h3c;
  assign ram_read_data = mem[ram_pointer];
  // Pointer has already moved on when the strobe arrives
  always @(posedge clk) if (ram_write_stb) mem[ram_pointer - 9'h001] <= ram_write_data;
endmodule
`default_nettype wire

// File: tb/tb_rtc_ctrl_ts_regs.sv
// Self-checking bench for the control and timestamp register bank.
// Drives the byte request port directly; a RAM model sits on the array port.
`timescale 1ns/1ps
`default_nettype none
module tb_rtc_control_timestamp_regs
  import rtc_pkg::*;
();
  logic clk;
  logic rst = 1'b1;
  rtc_req_s req = '0;
  rtc_rsp_s rsp;
  logic capture_stb = 1'b0;
  logic midlevel_detect = 1'b0;
  rtc_time_s live_time = '0;
  logic [2:0] clock_output_freq_sel = 3'h0;
  logic clock_output_pin_enable, external_clock_test_select, clock_halt, divider_clear, midlevel_irq;
  logic poweron_override_enable, hour_mode_12, minute_irq_enable, second_irq_enable, ram_write_stb, ram_read_stb;
  logic [3:0] aging_trim;
  logic [8:0] ram_pointer;
  logic [7:0] ram_write_data, ram_read_data, got;
  int error_cnt = 0;
  int samples_checked = 0;
  // Rows of {offset, write byte, read-back byte}
  logic [23:0] rows [15] = '{24'h00ffaf, 24'h000000, 24'h01ff00, 24'h02ff00, 24'h05ff00, 24'h13ff7f,
    24'h14ff7f, 24'h15ff3f, 24'h16ff3f, 24'h17ff1f, 24'h18ffff, 24'h19ff0f, 24'h1aff01, 24'h1b5a5a, 24'h1eff00};
  logic [47:0] stamp_exp = 48'h99_12_31_23_59_59;

  rtc_control_timestamp_regs i_rtc_control_timestamp_regs (.clk(clk), .rst(rst), .req(req), .rsp(rsp),
    .capture_stb(capture_stb), .midlevel_detect(midlevel_detect), .live_time(live_time),
    .clock_output_freq_sel(clock_output_freq_sel),
    .clock_output_pin_enable(clock_output_pin_enable), .external_clock_test_select(external_clock_test_select),
    .clock_halt(clock_halt), .divider_clear(divider_clear), .midlevel_irq(midlevel_irq),
    .poweron_override_enable(poweron_override_enable), .hour_mode_12(hour_mode_12),
    .minute_irq_enable(minute_irq_enable), .second_irq_enable(second_irq_enable), .aging_trim(aging_trim),
    .ram_pointer(ram_pointer), .ram_write_stb(ram_write_stb), .ram_write_data(ram_write_data),
    .ram_read_stb(ram_read_stb), .ram_read_data(ram_read_data));
  rtc_ram_model i_rtc_ram_model (.clk(clk), .ram_pointer(ram_pointer), .ram_write_stb(ram_write_stb),
    .ram_write_data(ram_write_data), .ram_read_data(ram_read_data));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    if (error_cnt == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk) req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge clk) req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk) req.rd <= 1'b0;
    #1;
    for (n = 0; n < 4 && rsp.valid !== 1'b1; n++) @(posedge clk) #1;
    if (n == 4) begin
      error_cnt++;
      final_report();
    end
    got = rsp.data;
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(ADDR_CONTROL_STATUS_1);
    check(got, RESET_CONTROL_STATUS_1);
    check(poweron_override_enable, 1'b1);
    check(ram_pointer, RESET_RAM_POINTER);
    // Rows include a set reserved bit and a later clear of the override enable
    foreach (rows[i]) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16]);
      check(got, rows[i][7:0]);
    end
    @(posedge clk) midlevel_detect <= 1'b1;
    @(posedge clk) midlevel_detect <= 1'b0;
    wr(ADDR_CONTROL_STATUS_1, 8'h10);
    #1 check(midlevel_irq, 1'b1);
    // Event and host clear in one cycle: the event wins
    @(posedge clk) begin
      midlevel_detect <= 1'b1;
      req <= '{wr: 1'b1, rd: 1'b0, addr: ADDR_CONTROL_STATUS_1, wdata: 8'h00};
    end
    @(posedge clk) begin
      midlevel_detect <= 1'b0;
      req.wr <= 1'b0;
    end
    #1 check(midlevel_irq, 1'b1);
    wr(ADDR_CONTROL_STATUS_1, 8'h00);
    #1 check(midlevel_irq, 1'b0);
    // Capture, then a mid-run reset that must spare the stamp
    @(posedge clk) begin
      live_time <= 48'h99_92_b1_e3_d9_d9;
      capture_stb <= 1'b1;
    end
    @(posedge clk) capture_stb <= 1'b0;
    @(posedge clk) rst <= 1'b1;
    @(posedge clk) rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      rd(ADDR_TIMESTAMP_SECONDS + 8'(i));
      check(got, stamp_exp[8*i +: 8]);
    end
    wr(ADDR_CONTROL_STATUS_1, 8'h87);
    #1 check({external_clock_test_select, hour_mode_12, minute_irq_enable, second_irq_enable}, 4'hf);
    check(aging_trim, RESET_AGING_TRIM);
    wr(ADDR_CONTROL_STATUS_1, 8'h20);
    for (int s = 2; s < 4; s++) begin
      @(posedge clk) clock_output_freq_sel <= 3'(s);
      @(posedge clk) #1 check(clock_output_pin_enable, (s < 3));
      check(divider_clear, 1'b1);
    end
    // Pointer wraps at the top of the array
    wr(ADDR_RAM_POINTER_HIGH, 8'h01);
    wr(ADDR_RAM_POINTER_LOW, 8'hff);
    wr(ADDR_RAM_WRITE_PORT, 8'ha5);
    #1 check(ram_write_stb, 1'b1);
    check(ram_pointer, 9'h000);
    wr(ADDR_RAM_POINTER_HIGH, 8'h01);
    wr(ADDR_RAM_POINTER_LOW, 8'hff);
    rd(ADDR_RAM_READ_PORT);
    check(got, 8'ha5);
    check(ram_read_stb, 1'b1);
    rd(ADDR_RAM_WRITE_PORT);
    check(got, 8'h00);
    final_report();
  end
endmodule
`default_nettype wire
